// ===== hw/spm_pkg.sv
// Package for the serial port prescale and interrupt mask register bank.
// Assumes a 32-bit plain register port and one 20 MHz system clock.
package spm_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] SPM_OFS_PRESCALE  = 12'h010;
  localparam logic [11:0] SPM_OFS_IRQ_MASK  = 12'h014;
  localparam logic [11:0] SPM_OFS_RAW_STAT  = 12'h018;
  localparam logic [11:0] SPM_OFS_MASK_STAT = 12'h01C;
  localparam logic [11:0] SPM_OFS_EVT_STAT  = 12'h030;
  localparam logic [11:0] SPM_OFS_EVT_MASK  = 12'h034;

  // ------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------
  localparam int          SPM_NIRQ          = 4;
  localparam int          SPM_PSC_W         = 8;
  localparam int          SPM_BIT_ROR       = 0;
  localparam int          SPM_BIT_RT        = 1;
  localparam int          SPM_BIT_RX        = 2;
  localparam int          SPM_BIT_TX        = 3;
  localparam logic [7:0]  SPM_PSC_RST       = 8'h02;
  localparam logic [3:0]  SPM_MASK_RST      = 4'h0;
  localparam logic [7:0]  SPM_PSC_EVEN      = 8'hFE;

  // Interrupt enables, bit 3 down to 0
  typedef struct packed {
    logic tx_level_irq_enable;
    logic rx_level_irq_enable;
    logic rx_timeout_irq_enable;
    logic rx_overrun_irq_enable;
  } spm_mask_t;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spm_req_t;

endpackage

// ===== hw/spm_prescaler.sv
// Even prescaler: makes a one-cycle base tick every divisor clocks.
// Assumes the divisor is even and at least 2; zero is held as 2.
`timescale 1ns/10ps
module spm_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Divisor and tick
  input  wire logic [W-1:0] divisor,
  output logic              tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] last;

  // Terminal count; a zero divisor acts as the smallest legal one
  assign last = (divisor < W'(2)) ? W'(1) : divisor - W'(1);

  // ------------------------------------------------------------------
  // Counter, restarts when a new divisor lands below the count
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick  <= 1'b0;
    end
  end

endmodule

// ===== hw/spm_irq_gate.sv
// Masked status gate: AND of raw status with the mask bits.
// Assumes raw status comes from logic on the same clock.
`timescale 1ns/10ps
module spm_irq_gate #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Raw status and mask
  input  wire logic [N-1:0] raw,
  input  wire logic [N-1:0] mask,
  output logic      [N-1:0] masked
);

  // ------------------------------------------------------------------
  // Registered gate, one bit per source
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!resetn) masked[i] <= 1'b0;
      else         masked[i] <= raw[i] & mask[i];
    end
  end

endmodule

// ===== hw/spm_top.sv
// Prescale and interrupt mask register bank of a sync serial port.
// Assumes a same-clock register master and raw status from port logic.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module spm_top #(
  parameter int PSC_W = spm_pkg::SPM_PSC_W,
  parameter int NIRQ  = spm_pkg::SPM_NIRQ
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Raw interrupt sources from the port logic
  input  wire logic [NIRQ-1:0]   raw_irq_status,
  // Outputs to the port logic and the system
  output logic                   base_tick,
  output logic      [NIRQ-1:0]   masked_irq_status,
  output logic      [PSC_W-1:0]  clock_prescale_divisor,
  output logic                   irq
);

  spm_pkg::spm_req_t  req;
  spm_pkg::spm_mask_t interrupt_mask_r;
  logic [NIRQ-1:0]    mask_bits;
  logic [1:0]         evt_stat_r;
  logic [1:0]         evt_mask_r;
  logic [1:0]         evt_in;
  logic [NIRQ-1:0]    masked_prev_r;
  logic [31:0]        rdata_nxt;
  logic               wr_psc;
  logic               wr_msk;

  assign req       = '{addr: reg_addr, wdata: reg_wdata,
                       wr: reg_wr, rd: reg_rd};
  assign mask_bits = interrupt_mask_r;
  assign wr_psc    = req.wr && req.addr == spm_pkg::SPM_OFS_PRESCALE;
  assign wr_msk    = req.wr && req.addr == spm_pkg::SPM_OFS_IRQ_MASK;

  // ------------------------------------------------------------------
  // Prescale register
  // ------------------------------------------------------------------
  // Bit 0 is forced low on store; odd values are not refused, since
  // keeping the value legal is software's job
  always_ff @(posedge clk) begin
    if (!resetn)
      clock_prescale_divisor <= spm_pkg::SPM_PSC_RST;
    else if (wr_psc)
      clock_prescale_divisor <= req.wdata[PSC_W-1:0] &
                                spm_pkg::SPM_PSC_EVEN;
  end

  // ------------------------------------------------------------------
  // Interrupt mask register
  // ------------------------------------------------------------------
  // Only the low four bits exist; upper write data is dropped
  always_ff @(posedge clk) begin
    if (!resetn)
      interrupt_mask_r <= spm_pkg::SPM_MASK_RST;
    else if (wr_msk)
      interrupt_mask_r <= req.wdata[NIRQ-1:0];
  end

  // ------------------------------------------------------------------
  // Base clock divider and masked status
  // ------------------------------------------------------------------
  spm_prescaler #(
    .W       (PSC_W)
  ) u_psc (
    .clk     (clk),
    .resetn  (resetn),
    .divisor (clock_prescale_divisor),
    .tick    (base_tick)
  );

  // Bit order ties enables to sources
  spm_irq_gate #(
    .N      (NIRQ)
  ) u_gate (
    .clk    (clk),
    .resetn (resetn),
    .raw    (raw_irq_status),
    .mask   (mask_bits),
    .masked (masked_irq_status)
  );

  // ------------------------------------------------------------------
  // Block events: bit 0 a masked source rose, bit 1 an odd divisor
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) masked_prev_r <= '0;
    else         masked_prev_r <= masked_irq_status;
  end

  assign evt_in = {wr_psc & req.wdata[0],
                   |(masked_irq_status & ~masked_prev_r)};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn)
      evt_stat_r <= '0;
    else if (req.wr && req.addr == spm_pkg::SPM_OFS_EVT_STAT)
      evt_stat_r <= (evt_stat_r & ~req.wdata[1:0]) | evt_in;
    else
      evt_stat_r <= evt_stat_r | evt_in;
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      evt_mask_r <= '0;
    else if (req.wr && req.addr == spm_pkg::SPM_OFS_EVT_MASK)
      evt_mask_r <= req.wdata[1:0];
  end

  // Level output, registered so it lags the status by one cycle
  always_ff @(posedge clk) begin
    if (!resetn) irq <= 1'b0;
    else         irq <= |(evt_stat_r & evt_mask_r);
  end

  // ------------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  // ------------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    unique case (req.addr)
      spm_pkg::SPM_OFS_PRESCALE:  rdata_nxt[PSC_W-1:0] =
                                    clock_prescale_divisor;
      spm_pkg::SPM_OFS_IRQ_MASK:  rdata_nxt[NIRQ-1:0] =
                                    mask_bits;
      spm_pkg::SPM_OFS_RAW_STAT:  rdata_nxt[NIRQ-1:0] = raw_irq_status;
      spm_pkg::SPM_OFS_MASK_STAT: rdata_nxt[NIRQ-1:0] =
                                    masked_irq_status;
      spm_pkg::SPM_OFS_EVT_STAT:  rdata_nxt[1:0] = evt_stat_r;
      spm_pkg::SPM_OFS_EVT_MASK:  rdata_nxt[1:0] = evt_mask_r;
      default:                    rdata_nxt = '0;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn)     reg_rdata <= '0;
    else if (req.rd) reg_rdata <= rdata_nxt;
    else             reg_rdata <= '0;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_psc_even;
    @(posedge clk) disable iff (!resetn)
      wr_psc |=> clock_prescale_divisor ==
                 ($past(reg_wdata[PSC_W-1:0]) & spm_pkg::SPM_PSC_EVEN);
  endproperty
  a_psc_even: assert property (p_psc_even)
    else $error("prescale write not stored with bit 0 low");

  property p_psc_lsb;
    @(posedge clk) disable iff (!resetn) !clock_prescale_divisor[0];
  endproperty
  a_psc_lsb: assert property (p_psc_lsb)
    else $error("prescale bit 0 set");

  property p_tick_period;
    @(posedge clk) disable iff (!resetn)
      ($rose(base_tick) && clock_prescale_divisor == 8'h02 &&
       $stable(clock_prescale_divisor) && !wr_psc) |-> ##2 base_tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("base tick not every two clocks at divisor 2");

  property p_mask_reset;
    @(posedge clk) $rose(resetn) |-> interrupt_mask_r == 4'h0;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not clear after reset");

  property p_mask_write;
    @(posedge clk) disable iff (!resetn)
      wr_msk |=> mask_bits == $past(reg_wdata[NIRQ-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_mask_hold;
    @(posedge clk) disable iff (!resetn)
      !wr_msk |=> $stable(mask_bits);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without write");

  property p_mask_read;
    @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == spm_pkg::SPM_OFS_IRQ_MASK)
        |=> reg_rdata == {28'h000_0000, $past(mask_bits)};
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read wrong or upper bits set");

  property p_ror_gate;
    @(posedge clk) disable iff (!resetn)
      !mask_bits[spm_pkg::SPM_BIT_ROR] |=>
        !masked_irq_status[spm_pkg::SPM_BIT_ROR];
  endproperty
  a_ror_gate: assert property (p_ror_gate)
    else $error("overrun passed while masked");

  property p_masked_and;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> masked_irq_status ==
               ($past(raw_irq_status) & $past(mask_bits));
  endproperty
  a_masked_and: assert property (p_masked_and)
    else $error("masked status is not raw AND mask");

  property p_psc_hold;
    @(posedge clk) disable iff (!resetn)
      !wr_psc |=> $stable(clock_prescale_divisor);
  endproperty
  a_psc_hold: assert property (p_psc_hold)
    else $error("prescale changed without write");

  property p_tick_pulse;
    @(posedge clk) disable iff (!resetn)
      base_tick |=> !base_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("base tick longer than one cycle");

  // Divisor 6 checks a full count; a write inside the window voids it
  property p_tick_six;
    @(posedge clk) disable iff (!resetn)
      ($rose(base_tick) && clock_prescale_divisor == 8'h06 &&
       $stable(clock_prescale_divisor) && !wr_psc) ##1 (!wr_psc) [*4]
        |-> ##2 base_tick;
  endproperty
  a_tick_six: assert property (p_tick_six)
    else $error("base tick not every six clocks at divisor 6");

  property p_mask_clear;
    @(posedge clk) disable iff (!resetn)
      wr_msk |=> (mask_bits & ~$past(reg_wdata[NIRQ-1:0])) == '0;
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("mask bit written zero still set");

  // Set must win when a cause lands in the cycle of a clear
  property p_evt_set;
    @(posedge clk) disable iff (!resetn)
      (|evt_in) |=> (evt_stat_r & $past(evt_in)) == $past(evt_in);
  endproperty
  a_evt_set: assert property (p_evt_set)
    else $error("event cause did not set its status bit");

  property p_irq_on;
    @(posedge clk) disable iff (!resetn)
      (|(evt_stat_r & evt_mask_r)) |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("irq low with an unmasked event set");

  property p_irq_off;
    @(posedge clk) disable iff (!resetn)
      ((evt_stat_r & evt_mask_r) == '0) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with no unmasked event");

  property p_rdata_idle;
    @(posedge clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  // ------------------------------------------------------------------
  // Cover points for the main scenarios
  // ------------------------------------------------------------------
  c_psc_write: cover property (@(posedge clk) disable iff (!resetn)
    wr_psc);
  c_mask_all:  cover property (@(posedge clk) disable iff (!resetn)
    mask_bits == 4'hF);
  c_odd_psc:   cover property (@(posedge clk) disable iff (!resetn)
    wr_psc && req.wdata[0]);
  c_set_wins:  cover property (@(posedge clk) disable iff (!resetn)
    evt_in[0] && req.wr && req.addr == spm_pkg::SPM_OFS_EVT_STAT);
  c_irq:       cover property (@(posedge clk) disable iff (!resetn)
    $rose(irq));

endmodule

// ===== dv/spm_top_bench.sv
// Self-checking bench for the prescale and interrupt mask register bank.
// Assumes the hw/ package and modules are compiled ahead of this file.
`timescale 1ns/10ps
module spm_top_bench;
  // ------------------------------------------------------------------
  // Signals and table of ordinary cases
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } spm_row_t;

  logic        clk            = 1'b0;
  logic        resetn         = 1'b0;
  logic [11:0] reg_addr       = 12'h000;
  logic [31:0] reg_wdata      = 32'h0000_0000;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0]  raw_irq_status = 4'h0;
  logic        base_tick;
  logic [3:0]  masked_irq_status;
  logic [7:0]  clock_prescale_divisor;
  logic        irq;
  int          error_cnt      = 0;
  int          n_checks       = 0;
  int          n;
  logic [31:0] dv [3] = '{32'h0000_0002, 32'h0000_0006, 32'h0000_00FE};
  // Write, then read back what should stand there
  spm_row_t    rows [11] = '{
    '{12'h010, 32'h0000_0002, 32'h0000_0002},
    '{12'h010, 32'h0000_00FE, 32'h0000_00FE},
    '{12'h010, 32'h0000_0007, 32'h0000_0006},
    '{12'h010, 32'hFFFF_FF55, 32'h0000_0054},
    '{12'h014, 32'h0000_0001, 32'h0000_0001},
    '{12'h014, 32'h0000_0002, 32'h0000_0002},
    '{12'h014, 32'h0000_0004, 32'h0000_0004},
    '{12'h014, 32'h0000_0008, 32'h0000_0008},
    '{12'h014, 32'hFFFF_FFF5, 32'h0000_0005},
    '{12'h014, 32'h0000_0000, 32'h0000_0000},
    '{12'h040, 32'hFFFF_FFFF, 32'h0000_0000}};

  // 50 ns period
  always #25 clk = ~clk;

  spm_top spm_top_inst (
    .clk                    (clk),
    .resetn                 (resetn),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .raw_irq_status         (raw_irq_status),
    .base_tick              (base_tick),
    .masked_irq_status      (masked_irq_status),
    .clock_prescale_divisor (clock_prescale_divisor),
    .irq                    (irq)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Sample 1 ns after the edge so its updates have landed
  task automatic settle(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk_val("reg_rdata", e, reg_rdata);
  endtask

  // Cycles between two ticks; bounded so a dead divider cannot hang
  task automatic tick_gap(output int g);
    g = 0;
    for (int i = 0; i < 600 && base_tick !== 1'b1; i++) begin
      settle(1);
    end
    settle(1);
    g = 1;
    while (base_tick !== 1'b1 && g < 600) begin
      settle(1);
      g++;
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    settle(19);
    chk_val("divisor", 32'h0000_0002, {24'h00_0000, clock_prescale_divisor});
    chk_val("irq", 32'h0000_0000, {31'h0000_0000, irq});
    // Released on the 20th edge, so twenty edges see reset low
    @(posedge clk) resetn <= 1'b1;
    rd(12'h014, 32'h0000_0000);
    rd(12'h010, 32'h0000_0002);
    settle(1);
    chk_val("rdata_idle", 32'h0000_0000, reg_rdata);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Each mask bit passes only its own source
    for (int b = 0; b < 4; b++) begin
      @(posedge clk) raw_irq_status <= 4'hF;
      wr(12'h014, 32'h0000_0001 << b);
      settle(3);
      chk_val("masked", 32'h0000_0001 << b,
              32'(masked_irq_status));
      rd(12'h01C, 32'h0000_0001 << b);
      @(posedge clk) raw_irq_status <= ~(4'h1 << b);
      settle(3);
      chk_val("masked", 32'h0000_0000,
              32'(masked_irq_status));
    end
    @(posedge clk) raw_irq_status <= 4'hF;
    wr(12'h01C, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0008);
    // First gap after a change may be short, so the second is measured
    for (int k = 0; k < 3; k++) begin
      wr(12'h010, dv[k]);
      tick_gap(n);
      tick_gap(n);
      chk_val("tick_gap", dv[k], 32'(n));
    end
    // Sticky event, level irq, mask and clear
    @(posedge clk) raw_irq_status <= 4'h0;
    wr(12'h014, 32'h0000_0001);
    wr(12'h030, 32'hFFFF_FFFF);
    wr(12'h034, 32'h0000_0001);
    raw_irq_status <= 4'h1;
    settle(5);
    chk_val("irq", 32'h0000_0001, {31'h0000_0000, irq});
    @(posedge clk) raw_irq_status <= 4'h0;
    settle(4);
    chk_val("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(12'h030, 32'h0000_0001);
    settle(3);
    chk_val("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wr(12'h034, 32'h0000_0000);
    raw_irq_status <= 4'h1;
    settle(5);
    chk_val("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rd(12'h030, 32'h0000_0001);
    wr(12'h034, 32'h0000_0001);
    settle(3);
    chk_val("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(12'h030, 32'h0000_0001);
    settle(3);
    chk_val("irq", 32'h0000_0000, {31'h0000_0000, irq});
    // Odd divisor event, then a clear of both event bits
    wr(12'h010, 32'h0000_0007);
    rd(12'h030, 32'h0000_0002);
    @(posedge clk) raw_irq_status <= 4'h0;
    wr(12'h030, 32'h0000_0003);
    rd(12'h030, 32'h0000_0000);
    // Raw rise is seen by the status in the cycle the clear lands
    @(posedge clk) raw_irq_status <= 4'h1;
    wr(12'h030, 32'h0000_0001);
    rd(12'h030, 32'h0000_0001);
    chk_val("irq", 32'h0000_0001, 32'(irq));
    // Reset in mid-run puts every output back to its idle value
    @(posedge clk) resetn <= 1'b0;
    settle(2);
    chk_val("divisor", 32'h0000_0002, 32'(clock_prescale_divisor));
    chk_val("masked", 32'h0000_0000, 32'(masked_irq_status));
    chk_val("irq", 32'h0000_0000, 32'(irq));
    chk_val("base_tick", 32'h0000_0000, 32'(base_tick));
    chk_val("rdata_rst", 32'h0000_0000, reg_rdata);
    @(posedge clk) resetn <= 1'b1;
    rd(12'h014, 32'h0000_0000);
    rd(12'h010, 32'h0000_0002);
    final_report();
  end

  // Watchdog: the tests take about 1000 cycles
  initial begin
    #(20000 * 50);
    error_cnt++;
    final_report();
  end
endmodule
